/* File: design/lcdsps_top.sv */
// Our own choice: register access over APB.
`timescale 1ns/1ps
`include "lcdsps_map.svh"

module lcdsps_top (
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [19:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire lcdsps_pkg::lcdsps_drive_t port_drive,
  input wire logic [1:0] lcd_mode,
  input wire logic [31:0] seg_wave,
  input wire logic [31:0] pad_in,
  output lcdsps_pkg::lcdsps_pad_t pad,
  output logic [31:0] port_in,
  output logic [31:0] sel_seg
);

  lcdsps_pkg::lcdsps_state_t st_reg;
  lcdsps_pkg::lcdsps_state_t st_next;

  // Bus phase decode
  logic setup_phase;
  logic access_phase;
  logic access_done;
  logic lane0_valid;
  logic wr_commit;

  // Address decode
  logic [17:0] reg_idx;
  logic addr_aligned;
  logic hit_port_c;
  logic hit_port_d;
  logic hit_port_e;
  logic hit_port_f;
  logic hit_sel;
  logic hit_status;
  logic [1:0] sel_group;
  logic refuse;

  // Per-port views of the select bits; bit n of each view is pin n of that port
  logic [7:0] sel_port_c;
  logic [7:0] sel_port_d;
  logic [7:0] sel_port_e;
  logic [7:0] sel_port_f;

  // Read path
  logic [7:0] sel_read;
  logic [31:0] read_value;
  logic [31:0] prdata_next;
  logic pslverr_next;

  // Per-group write strobes and summaries
  logic [`LCDSPS_GROUPS-1:0] grp_hit;
  logic [`LCDSPS_GROUPS-1:0] grp_wr;
  logic [`LCDSPS_GROUPS-1:0] grp_any;
  logic [`LCDSPS_GROUPS-1:0] grp_all;

  // Pin side
  logic [31:0] sel_flat;
  logic display_on;
  logic [7:0] status_next;

  assign sel_flat = st_reg.sel;
  assign display_on = (lcd_mode != `LCDSPS_MODE_STOP);

  assign sel_port_c = st_reg.sel[`LCDSPS_PORT_C];
  assign sel_port_d = st_reg.sel[`LCDSPS_PORT_D];
  assign sel_port_e = st_reg.sel[`LCDSPS_PORT_E];
  assign sel_port_f = st_reg.sel[`LCDSPS_PORT_F];

  assign reg_idx = paddr[19:2];
  assign addr_aligned = (paddr[1:0] == 2'h0);

  assign setup_phase = psel && !penable;
  assign access_phase = psel && penable;
  // The access only ends in the cycle in which our own registered ready stands
  assign access_done = access_phase && st_reg.pready;
  // Only byte lane 0 carries register bits; other lanes are ignored
  assign lane0_valid = pstrb[0];
  assign wr_commit = access_done && pwrite && lane0_valid;

  // Address decode: indices map to word addresses
  always_comb begin
    hit_port_c = 1'b0;
    hit_port_d = 1'b0;
    hit_port_e = 1'b0;
    hit_port_f = 1'b0;
    hit_status = 1'b0;
    if (!addr_aligned) begin
      hit_status = 1'b0;
    end else if (reg_idx == `LCDSPS_IDX_PORT_C) begin
      hit_port_c = 1'b1;
    end else if (reg_idx == `LCDSPS_IDX_PORT_D) begin
      hit_port_d = 1'b1;
    end else if (reg_idx == `LCDSPS_IDX_PORT_E) begin
      hit_port_e = 1'b1;
    end else if (reg_idx == `LCDSPS_IDX_PORT_F) begin
      hit_port_f = 1'b1;
    end else if (reg_idx == `LCDSPS_IDX_STATUS) begin
      hit_status = 1'b1;
    end
  end

  assign hit_sel = hit_port_c || hit_port_d || hit_port_e || hit_port_f;

  // Group index of the addressed select register
  always_comb begin
    sel_group = `LCDSPS_PORT_C;
    if (hit_port_d) begin
      sel_group = `LCDSPS_PORT_D;
    end else if (hit_port_e) begin
      sel_group = `LCDSPS_PORT_E;
    end else if (hit_port_f) begin
      sel_group = `LCDSPS_PORT_F;
    end
  end

  // Select byte seen by a read
  always_comb begin
    sel_read = 8'h00;
    if (hit_port_c) begin
      sel_read = sel_port_c;
    end else if (hit_port_d) begin
      sel_read = sel_port_d;
    end else if (hit_port_e) begin
      sel_read = sel_port_e;
    end else if (hit_port_f) begin
      sel_read = sel_port_f;
    end
  end

  // Read mux; upper bits of the word read as zero
  always_comb begin
    read_value = 32'h0000_0000;
    if (hit_sel) begin
      read_value = {24'h00_0000, sel_read};
    end else if (hit_status) begin
      read_value = {24'h00_0000, st_reg.status};
    end
  end

  // Status is read-only; unmapped or misaligned addresses are refused
  assign refuse = !(hit_sel || (hit_status && !pwrite));

  // Response is captured in setup so that it stands with ready in the access cycle
  always_comb begin
    prdata_next = st_reg.prdata;
    pslverr_next = st_reg.pslverr;
    if (setup_phase) begin
      prdata_next = pwrite ? 32'h0000_0000 : read_value;
      pslverr_next = refuse;
    end else if (access_done) begin
      prdata_next = 32'h0000_0000;
      pslverr_next = 1'b0;
    end
  end

  // One write strobe and two summaries (any pin, all pins) per select register
  genvar k;
  generate
    for (k = 0; k < `LCDSPS_GROUPS; k = k + 1) begin : g_grp
      assign grp_hit[k] = hit_sel && (sel_group == 2'(k));
      assign grp_wr[k] = grp_hit[k] && wr_commit;
      assign grp_any[k] = |st_reg.sel[k];
      assign grp_all[k] = &st_reg.sel[k];
    end
  endgenerate

  // Status: mode in the low bits, then whether any or all pins are segments
  always_comb begin
    status_next = 8'h00;
    status_next[`LCDSPS_STAT_MODE_MSB:`LCDSPS_STAT_MODE_LSB] = lcd_mode;
    status_next[`LCDSPS_STAT_ANY_SEG] = |grp_any;
    status_next[`LCDSPS_STAT_ALL_SEG] = &grp_all;
  end

  always_comb begin
    st_next = st_reg;
    // No wait state: pready stands in the first access cycle, data prepared in setup
    st_next.pready = setup_phase;
    st_next.prdata = prdata_next;
    st_next.pslverr = pslverr_next;
    // A refused or lane-less write leaves every select untouched
    for (int i = 0; i < `LCDSPS_GROUPS; i++) begin
      if (grp_wr[i]) begin
        st_next.sel[i] = pwdata[7:0];
      end
    end
    st_next.status = status_next;
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      st_reg.sel <= {`LCDSPS_GROUPS{`LCDSPS_SEL_RESET}};
      st_reg.prdata <= 32'h0000_0000;
      st_reg.pready <= 1'b0;
      st_reg.pslverr <= 1'b0;
      st_reg.status <= 8'h00;
    end else begin
      st_reg <= st_next;
    end
  end

  // Pin cells register the pad, so the pins follow sel_seg one edge later
  genvar g;
  generate
    for (g = 0; g < `LCDSPS_PINS; g = g + 1) begin : g_pin
      lcdsps_pin_cell u_cell (
        .core_clk(core_clk),
        .nrst(nrst),
        .sel_seg(sel_flat[g]),
        .display_on(display_on),
        .seg_level(seg_wave[g]),
        .port_out(port_drive.out[g]),
        .port_oe(port_drive.oe[g]),
        .pad_in(pad_in[g]),
        .pad_out(pad.out[g]),
        .pad_oe(pad.oe[g]),
        .port_in(port_in[g])
      );
    end
  endgenerate

  assign prdata = st_reg.prdata;
  assign pready = st_reg.pready;
  assign pslverr = st_reg.pslverr;
  assign sel_seg = sel_flat;

endmodule : lcdsps_top

/* File: pkg/lcdsps_map.svh */
`ifndef LCDSPS_MAP_SVH
`define LCDSPS_MAP_SVH

// Register indices; the byte address on the bus is four times the index
`define LCDSPS_IDX_PORT_C 18'h0F8F1
`define LCDSPS_IDX_PORT_D 18'h0F8F2
`define LCDSPS_IDX_PORT_E 18'h0F8F3
`define LCDSPS_IDX_PORT_F 18'h0F8F4
`define LCDSPS_IDX_STATUS 18'h0F8F5

`define LCDSPS_SEL_RESET 8'h00
`define LCDSPS_GROUPS 4
`define LCDSPS_PINS 32
`define LCDSPS_PORT_C 2'h0
`define LCDSPS_PORT_D 2'h1
`define LCDSPS_PORT_E 2'h2
`define LCDSPS_PORT_F 2'h3

// Display mode codes as seen on lcd_mode
`define LCDSPS_MODE_STOP 2'h0

// Status register fields
`define LCDSPS_STAT_MODE_LSB 0
`define LCDSPS_STAT_MODE_MSB 1
`define LCDSPS_STAT_ANY_SEG 2
`define LCDSPS_STAT_ALL_SEG 3

`endif

/* File: pkg/lcdsps_pkg.sv */
package lcdsps_pkg;

  // Port logic drive toward the pins, one bit per shared pin
  typedef struct packed {
    logic [31:0] out;
    logic [31:0] oe;
  } lcdsps_drive_t;

  // Pad drive produced by the block
  typedef struct packed {
    logic [31:0] out;
    logic [31:0] oe;
  } lcdsps_pad_t;

  typedef struct packed {
    logic [3:0][7:0] sel;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic [7:0] status;
  } lcdsps_state_t;

  typedef struct packed {
    logic in_meta;
    logic in_sync;
    logic port_in;
    logic pad_out;
    logic pad_oe;
  } lcdsps_cell_t;

endpackage : lcdsps_pkg

/* File: design/lcdsps_pin_cell.sv */
`timescale 1ns/1ps
`include "lcdsps_map.svh"

module lcdsps_pin_cell (
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic sel_seg,
  input wire logic display_on,
  input wire logic seg_level,
  input wire logic port_out,
  input wire logic port_oe,
  input wire logic pad_in,
  output logic pad_out,
  output logic pad_oe,
  output logic port_in
);

  lcdsps_pkg::lcdsps_cell_t st_reg;
  lcdsps_pkg::lcdsps_cell_t st_next;

  always_comb begin
    st_next = st_reg;
    st_next.in_meta = pad_in;
    st_next.in_sync = st_reg.in_meta;
    if (sel_seg) begin
      st_next.pad_oe = 1'b1;
      // Held at ground until the display runs, so the panel sees no DC
      st_next.pad_out = display_on ? seg_level : 1'b0;
      // Port logic reads a quiet zero instead of its own segment waveform
      st_next.port_in = 1'b0;
    end else begin
      st_next.pad_oe = port_oe;
      st_next.pad_out = port_out;
      st_next.port_in = st_reg.in_sync;
    end
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign pad_out = st_reg.pad_out;
  assign pad_oe = st_reg.pad_oe;
  assign port_in = st_reg.port_in;

endmodule : lcdsps_pin_cell

/* File: verification/lcdsps_far.sv */
`timescale 1ns/1ps

module lcdsps_far (
  input wire lcdsps_pkg::lcdsps_pad_t pad,
  input wire logic [31:0] ext,
  output logic [31:0] pad_in
);
  // A pin the pad does not drive shows whatever the far end puts on it through ext
  assign pad_in = (pad.oe & pad.out) | (~pad.oe & ext);
endmodule : lcdsps_far

/* File: verification/lcdsps_chk.sv */
`timescale 1ns/1ps
`include "lcdsps_map.svh"

module lcdsps_chk (
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [19:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire lcdsps_pkg::lcdsps_drive_t port_drive,
  input wire logic [1:0] lcd_mode,
  input wire logic [31:0] seg_wave,
  input wire lcdsps_pkg::lcdsps_pad_t pad,
  input wire logic [31:0] sel_seg
);
  logic [17:0] grp;
  logic setup;
  logic done;
  // Below port C the subtraction wraps, so those indices count as unmapped
  assign grp = paddr[19:2] - `LCDSPS_IDX_PORT_C;
  assign setup = psel && !penable;
  assign done = psel && penable && pready;
  default clocking @(posedge core_clk); endclocking
  default disable iff (!nrst);
  property p_ack; setup |=> pready; endproperty
  property p_one; pready |=> !pready; endproperty
  property p_err;
    setup && (paddr[1:0] != 2'h0 || grp > 18'h4 || (grp == 18'h4 && pwrite)) |=> pslverr;
  endproperty
  property p_wr;
    done && pwrite && !pslverr && pstrb[0] && grp < 18'h4
      |=> sel_seg[8*$past(grp[1:0]) +: 8] == $past(pwdata[7:0]);
  endproperty
  property p_rd;
    setup && !pwrite && paddr[1:0] == 2'h0 && grp < 18'h4
      |=> prdata == {24'h0, sel_seg[8*$past(grp[1:0]) +: 8]};
  endproperty
  property p_oe; nrst |=> pad.oe == ($past(sel_seg) | $past(port_drive.oe)); endproperty
  property p_out;
    nrst |=> pad.out == (($past(sel_seg) & $past(seg_wave) & {32{$past(lcd_mode) != 2'h0}})
      | (~$past(sel_seg) & $past(port_drive.out)));
  endproperty
  property p_keep; nrst && !$stable(sel_seg) |-> $past(done && pwrite); endproperty
  a_ack: assert property (p_ack) else $error("no ready after setup");
  a_one: assert property (p_one) else $error("ready too long");
  a_err: assert property (p_err) else $error("bad access not refused");
  a_wr: assert property (p_wr) else $error("write lost");
  a_rd: assert property (p_rd) else $error("read data wrong");
  a_oe: assert property (p_oe) else $error("pad enable wrong");
  a_out: assert property (p_out) else $error("pad level wrong");
  a_keep: assert property (p_keep) else $error("select changed alone");
  c_wr: cover property (done && pwrite && !pslverr);
  c_err: cover property (done && pslverr);
  c_seg: cover property (lcd_mode != 2'h0 && sel_seg != 32'h0);
endmodule : lcdsps_chk

bind lcdsps_top lcdsps_chk u_chk (.core_clk, .nrst, .psel, .penable, .pwrite, .paddr,
  .pwdata, .pstrb, .prdata, .pready, .pslverr, .port_drive, .lcd_mode, .seg_wave, .pad,
  .sel_seg);

/* File: verification/testbench.sv */
`timescale 1ns/1ps
`include "lcdsps_map.svh"

module testbench;
  logic core_clk, pready, pslverr, e;
  logic nrst = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [19:0] paddr = 20'h0;
  logic [31:0] pwdata = 32'h0, wave = 32'h0, ext = 32'h0, sel = 32'h0;
  logic [31:0] prdata, pad_in, port_in, sel_seg, r;
  logic [3:0] pstrb = 4'h0;
  logic [1:0] mode = 2'h0;
  lcdsps_pkg::lcdsps_drive_t drv = '0;
  lcdsps_pkg::lcdsps_pad_t pad;
  int mismatches, checked, cyc;
  logic [7:0] tv [4] = '{8'hA5, 8'h5A, 8'hFF, 8'h01};
  lcdsps_top uut (.core_clk, .nrst, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb,
    .prdata, .pready, .pslverr, .port_drive(drv), .lcd_mode(mode), .seg_wave(wave),
    .pad_in, .pad, .port_in, .sel_seg);
  lcdsps_far far (.pad, .ext, .pad_in);
  initial begin
    core_clk = 1'b0;
    forever #2.5 core_clk = ~core_clk;
  end
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 2000) begin
      mismatches++;
      results();
    end
  end
  task automatic results();
    $display("checked %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : results
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      mismatches++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic xfer(input logic w, input logic [17:0] ix, input logic [1:0] lo,
    input logic [3:0] s, input logic [7:0] d, input logic xe);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= {ix, lo};
    pwdata <= {24'h0, d};
    pstrb <= s;
    @(posedge core_clk);
    penable <= 1'b1;
    do @(posedge core_clk); while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    chk({31'h0, e}, {31'h0, xe});
    @(posedge core_clk);
  endtask : xfer
  task automatic pins();
    logic [31:0] oe, out;
    oe = sel | drv.oe;
    out = (sel & wave & {32{mode != 2'h0}}) | (~sel & drv.out);
    chk(pad.oe, oe);
    chk(pad.out, out);
    chk(port_in, ((oe & out) | (~oe & ext)) & ~sel);
  endtask : pins
  initial begin
    repeat (6) @(posedge core_clk);
    chk(pad.oe, 32'h0);
    nrst <= 1'b1;
    for (int g = 0; g < 4; g++) begin
      xfer(1'b0, `LCDSPS_IDX_PORT_C + 18'(g), 2'h0, 4'hF, 8'h00, 1'b0);
      chk(r, 32'h0);
    end
    $display("reset values test done");
    for (int g = 0; g < 4; g++) begin
      xfer(1'b1, `LCDSPS_IDX_PORT_C + 18'(g), 2'h0, 4'h1, tv[g], 1'b0);
      sel[8*g +: 8] = tv[g];
    end
    for (int g = 0; g < 4; g++) begin
      xfer(1'b0, `LCDSPS_IDX_PORT_C + 18'(g), 2'h0, 4'hF, 8'h00, 1'b0);
      chk(r, {24'h0, tv[g]});
    end
    chk(sel_seg, sel);
    $display("select register test done");
    drv <= '{out: 32'h0F0F_3C3C, oe: 32'h00FF_F00F};
    wave <= 32'h6996_A55A;
    ext <= 32'hC33C_5AA5;
    // Selects are already set, so every display mode is entered after them
    for (int m = 0; m < 4; m++) begin
      mode <= 2'(m);
      repeat (5) @(posedge core_clk);
      pins();
    end
    // Status: mode 3, some selects set, not all of them
    xfer(1'b0, `LCDSPS_IDX_STATUS, 2'h0, 4'hF, 8'h00, 1'b0);
    chk(r, 32'h0000_0007);
    $display("pin function test done");
    xfer(1'b1, `LCDSPS_IDX_PORT_C, 2'h0, 4'h0, 8'h00, 1'b0);
    xfer(1'b1, `LCDSPS_IDX_PORT_D, 2'h1, 4'hF, 8'h00, 1'b1);
    xfer(1'b1, `LCDSPS_IDX_STATUS, 2'h0, 4'hF, 8'h00, 1'b1);
    xfer(1'b0, `LCDSPS_IDX_STATUS + 18'h1, 2'h0, 4'hF, 8'h00, 1'b1);
    chk(sel_seg, sel);
    nrst <= 1'b0;
    @(posedge core_clk);
    chk(sel_seg, 32'h0);
    chk(pad.oe, 32'h0);
    sel = 32'h0;
    nrst <= 1'b1;
    repeat (5) @(posedge core_clk);
    pins();
    $display("refusal and reset test done");
    results();
  end
endmodule : testbench
